// ---- hw/pmr_regs.sv ----
// register bank of the battery power manager, reached as an i2c slave
// assumes scl and sda sampled synchronously, open-drain sda split in three
`timescale 1ns/1ps
module pmr_regs
    import pmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic sys_tick,
    input wire logic [15:0] touch_reading,
    input wire logic [9:0] vbat_sample,
    input wire logic [9:0] output_voltage_reading_sample,
    input wire logic [9:0] vin_sample,
    input wire logic host_boot_req,
    input wire logic host_up,
    input wire logic host_down,
    input wire logic [7:0] store_addr,
    input wire logic [7:0] store_lamp,
    input wire logic [7:0] store_cycles,
    input wire logic [7:0] store_level,
    input wire logic [7:0] store_margin,
    input wire logic [7:0] store_rtrim,
    input wire logic [7:0] store_ftrim,
    input wire logic store_load,
    output logic store_write,
    output logic [7:0] store_index,
    output logic [7:0] store_data,
    output logic [7:0] charge_cycles,
    output logic [7:0] osc_range_trim,
    output logic [7:0] osc_fine_trim,
    output logic host_power_en,
    output logic power_indicator_lamp
);
    typedef enum logic [5:0] {
        PMR_BUS_IDLE = 6'b000001,
        PMR_BUS_ADDR = 6'b000010,
        PMR_BUS_ACK = 6'b000100,
        PMR_BUS_WRITE = 6'b001000,
        PMR_BUS_READ = 6'b010000,
        PMR_BUS_RACK = 6'b100000
    } pmr_bus_t;

    pmr_bus_t bus_reg;
    pmr_host_t host_reg;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] shift_reg;
    logic [2:0] bit_reg;
    logic is_read_reg, have_ptr_reg, acking_reg;
    logic [7:0] ptr_reg;
    logic [7:0] addr_reg, lamp_reg, cycles_reg, level_reg, margin_reg;
    logic [7:0] rtrim_reg, ftrim_reg;
    logic [3:0] history;
    logic touched;
    logic [7:0] rd_byte;
    logic wr_strobe;
    logic [31:0] fast_cnt_reg;
    logic [31:0] pulse_cnt_reg;
    logic fast_phase_reg;
    logic [PMR_PWM_BITS-1:0] pwm_cnt_reg;
    logic pulse_level;

    // register read mux, shared by read shift and checks
    function automatic logic [7:0] pmr_read(input logic [7:0] idx);
        unique case (idx)
            PMR_OFF_VERSION: pmr_read = PMR_VERSION; // fixed code
            PMR_OFF_ADDR: pmr_read = {1'b0, addr_reg[6:0]};
            PMR_OFF_LAMP: pmr_read = lamp_reg;
            PMR_OFF_CYCLES: pmr_read = cycles_reg;
            PMR_OFF_LEVEL: pmr_read = level_reg;
            PMR_OFF_MARGIN: pmr_read = margin_reg;
            PMR_OFF_RTRIM: pmr_read = rtrim_reg;
            PMR_OFF_FTRIM: pmr_read = ftrim_reg;
            PMR_OFF_VBAT: pmr_read = vbat_sample[7:0];
            8'h1E: pmr_read = {6'h00, vbat_sample[9:8]};
            PMR_OFF_OUTPUT_VOLTAGE_READING: pmr_read = output_voltage_reading_sample[7:0];
            8'h20: pmr_read = {6'h00, output_voltage_reading_sample[9:8]};
            PMR_OFF_VIN: pmr_read = vin_sample[7:0];
            8'h22: pmr_read = {6'h00, vin_sample[9:8]};
            PMR_OFF_TOUCH: pmr_read = {4'h0, history};
            default: pmr_read = 8'h00;
        endcase
    endfunction

    // bus line edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_seen = scl_in && scl_q && sda_q && !sda_in;
    assign stop_seen = scl_in && scl_q && !sda_q && sda_in;
    assign rd_byte = pmr_read(ptr_reg);

    // i2c slave sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_reg <= PMR_BUS_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 3'h0;
            is_read_reg <= 1'b0;
            have_ptr_reg <= 1'b0;
            acking_reg <= 1'b0;
            ptr_reg <= 8'h00;
        end else if (start_seen) begin
            bus_reg <= PMR_BUS_ADDR;
            bit_reg <= 3'h0;
            have_ptr_reg <= 1'b0;
        end else if (stop_seen) begin
            bus_reg <= PMR_BUS_IDLE;
        end else begin
            unique case (bus_reg)
                PMR_BUS_IDLE: begin
                end
                PMR_BUS_ADDR: if (scl_rise) begin
                    shift_reg <= {shift_reg[6:0], sda_in};
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        acking_reg <= shift_reg[6:0] == addr_reg[6:0];
                        is_read_reg <= sda_in;
                        bus_reg <= PMR_BUS_ACK;
                    end
                end
                // ack slot opens at the fall after bit 8, ends at the next
                PMR_BUS_ACK: if (scl_fall) begin
                    if (!acking_reg) begin
                        bus_reg <= PMR_BUS_IDLE;
                    end else if (bit_reg == 3'h0) begin
                        bit_reg <= 3'h1;
                    end else if (is_read_reg) begin
                        shift_reg <= rd_byte;
                        bus_reg <= PMR_BUS_READ;
                        bit_reg <= 3'h0;
                    end else begin
                        bus_reg <= PMR_BUS_WRITE;
                        bit_reg <= 3'h0;
                    end
                end
                PMR_BUS_WRITE: if (scl_rise) begin
                    shift_reg <= {shift_reg[6:0], sda_in};
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        acking_reg <= 1'b1;
                        bus_reg <= PMR_BUS_ACK;
                        is_read_reg <= 1'b0;
                        have_ptr_reg <= 1'b1;
                        // first byte sets pointer, data advances it
                        ptr_reg <= have_ptr_reg ? ptr_reg + 8'h01
                            : {shift_reg[6:0], sda_in};
                    end
                end
                PMR_BUS_READ: if (scl_fall) begin
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        bus_reg <= PMR_BUS_RACK;
                    end
                end
                PMR_BUS_RACK: if (scl_rise) begin
                    ptr_reg <= ptr_reg + 8'h01;
                    acking_reg <= !sda_in;
                end else if (scl_fall) begin
                    // sda stays free in the master's slot; next byte on fall
                    shift_reg <= rd_byte;
                    bit_reg <= 3'h0;
                    bus_reg <= acking_reg ? PMR_BUS_READ : PMR_BUS_IDLE;
                end
            endcase
        end
    end

    // write strobe on last data bit; the pointer byte itself is not data
    assign wr_strobe = bus_reg == PMR_BUS_WRITE && scl_rise
        && bit_reg == 3'h7 && have_ptr_reg && !start_seen && !stop_seen;
    assign store_write = wr_strobe;
    assign store_index = ptr_reg;
    assign store_data = {shift_reg[6:0], sda_in};

    // open drain: pull low for ack or a zero data bit
    assign sda_oe = (bus_reg == PMR_BUS_ACK && acking_reg && bit_reg == 3'h1)
        || (bus_reg == PMR_BUS_READ && !shift_reg[7]);
    assign sda_out = 1'b0;

    // config from non-volatile store; writes go back out to it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= {1'b0, PMR_ADDR_RESET};
            lamp_reg <= PMR_LAMP_RESET;
            cycles_reg <= PMR_CYCLES_RESET;
            level_reg <= PMR_LEVEL_RESET;
            margin_reg <= PMR_MARGIN_RESET;
            rtrim_reg <= PMR_TRIM_RESET;
            ftrim_reg <= PMR_TRIM_RESET;
        end else if (store_load) begin
            addr_reg <= store_addr;
            lamp_reg <= store_lamp;
            cycles_reg <= store_cycles;
            level_reg <= store_level;
            margin_reg <= store_margin;
            rtrim_reg <= store_rtrim;
            ftrim_reg <= store_ftrim;
        end else if (wr_strobe) begin
            unique case (ptr_reg)
                PMR_OFF_ADDR: addr_reg <= {1'b0, store_data[6:0]};
                PMR_OFF_LAMP: lamp_reg <= store_data;
                PMR_OFF_CYCLES: cycles_reg <= store_data;
                PMR_OFF_LEVEL: level_reg <= store_data;
                PMR_OFF_MARGIN: margin_reg <= store_data;
                PMR_OFF_RTRIM: rtrim_reg <= store_data;
                PMR_OFF_FTRIM: ftrim_reg <= store_data;
                default: begin
                end
            endcase
        end
    end
    assign charge_cycles = cycles_reg;
    assign osc_range_trim = rtrim_reg;
    assign osc_fine_trim = ftrim_reg;

    // sampling only on the slow tick, whatever its rate
    pmr_touch u_touch (
        .clk(clk),
        .reset_n(reset_n),
        .reading_valid(sys_tick),
        .reading(touch_reading),
        .level(level_reg),
        .margin(margin_reg),
        .history(history),
        .touched(touched)
    );

    // host power state; a long hold during busy states is ignored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_reg <= PMR_HOST_OFF;
        end else begin
            unique case (host_reg)
                PMR_HOST_OFF: if (host_boot_req) host_reg <= PMR_HOST_BOOT;
                PMR_HOST_BOOT: if (host_up) host_reg <= PMR_HOST_ON;
                PMR_HOST_ON: if (history == PMR_HOLD_MASK)
                    host_reg <= PMR_HOST_SHDN;
                PMR_HOST_SHDN: if (host_down) host_reg <= PMR_HOST_OFF;
            endcase
        end
    end
    assign host_power_en = host_reg != PMR_HOST_OFF;

    // lamp pattern timers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fast_cnt_reg <= 32'h0;
            fast_phase_reg <= 1'b0;
        end else if (fast_cnt_reg == 32'(PMR_FAST_CYC - 1)) begin
            fast_cnt_reg <= 32'h0;
            fast_phase_reg <= !fast_phase_reg;
        end else begin
            fast_cnt_reg <= fast_cnt_reg + 32'h1;
        end
    end
    // pulse: pwm duty ramps with the slow counter's top bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_cnt_reg <= 32'h0;
            pwm_cnt_reg <= '0;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + PMR_PWM_BITS'(1);
            pulse_cnt_reg <= (pulse_cnt_reg == 32'(PMR_PULSE_CYC - 1))
                ? 32'h0 : pulse_cnt_reg + 32'h1;
        end
    end
    // divide first: the product form overflows 32 bits over a full ramp
    assign pulse_level = pwm_cnt_reg < 8'(pulse_cnt_reg
        / 32'(PMR_PULSE_CYC / 256 + 1));

    // device owns the lamp outside the on state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            power_indicator_lamp <= 1'b0;
        end else if (host_reg == PMR_HOST_OFF) begin
            power_indicator_lamp <= 1'b0;
        end else if (host_reg != PMR_HOST_ON) begin
            power_indicator_lamp <= pulse_level;
        end else begin
            unique case (lamp_reg[1:0])
                PMR_LAMP_OFF: power_indicator_lamp <= 1'b0;
                PMR_LAMP_ON: power_indicator_lamp <= 1'b1;
                PMR_LAMP_PULSE: power_indicator_lamp <= pulse_level;
                PMR_LAMP_FAST: power_indicator_lamp <= fast_phase_reg;
            endcase
        end
    end

    a_lamp_off: assert property (@(posedge clk) disable iff (!reset_n)
        host_reg == PMR_HOST_OFF |=> !power_indicator_lamp)
        else $error("lamp lit while host off");
    a_lamp_steady: assert property (@(posedge clk) disable iff (!reset_n)
        host_reg == PMR_HOST_ON && lamp_reg[1:0] == PMR_LAMP_ON
        |=> power_indicator_lamp)
        else $error("lamp not on for steady setting");
    a_ro_kept: assert property (@(posedge clk) disable iff (!reset_n)
        wr_strobe && !store_load && (ptr_reg == PMR_OFF_VERSION
        || ptr_reg == PMR_OFF_VBAT || ptr_reg == PMR_OFF_TOUCH)
        |=> $stable(lamp_reg) && $stable(addr_reg) && $stable(cycles_reg))
        else $error("write to read-only offset changed state");
    // contact shows in the touch byte
    a_touch_seen: assert property (@(posedge clk) disable iff (!reset_n)
        touched |-> pmr_read(PMR_OFF_TOUCH) != 8'h00)
        else $error("touch byte zero during contact");
    a_hist_zero: assert property (@(posedge clk) disable iff (!reset_n)
        history == 4'h0 |-> pmr_read(PMR_OFF_TOUCH) == 8'h00)
        else $error("touch byte nonzero without contact");
    a_hold_shdn: assert property (@(posedge clk) disable iff (!reset_n)
        host_reg == PMR_HOST_ON && history == PMR_HOLD_MASK
        |=> host_reg == PMR_HOST_SHDN)
        else $error("long hold did not start shutdown");
    // pointer steps after a read byte
    a_ptr_step: assert property (@(posedge clk) disable iff (!reset_n)
        bus_reg == PMR_BUS_RACK && scl_rise && !start_seen && !stop_seen
        |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("pointer did not advance after read");
endmodule

// ---- include/pmr_pkg.sv ----
// package for the power manager register bank: offsets, resets, timing
// assumes a single 50 MHz clock domain and a 7-bit i2c slave front end
//
// Notes on behaviour
// - answer i2c at address 0x43, changeable
// - read-only version byte at register 0x00
// - own bus address at 0x01, kept
// - lamp follows two-bit setting while host on
// - lamp off when host off, pulse when busy
// - last four samples shift in at 0x23
// - history zero untouched, nonzero on contact
// - long hold powers host off
// - charge cycle count per measurement, default 20
// - low-pass baseline tracks average reading
// - touch when reading above base+thr+hyst
// - release when reading below base+thr-hyst
// - two writable kept oscillator trim bytes
// - input voltage at 0x21, 10-bit little-endian
// - battery voltage at 0x1D, 10-bit little-endian
// - output voltage at 0x1F, 10-bit little-endian
// - configuration survives power loss
// - system tick slow and imprecise
package pmr_pkg;
    localparam logic [6:0] PMR_ADDR_RESET = 7'h43;
    // arbitrary neutral version value
    localparam logic [7:0] PMR_VERSION = 8'hA5;
    localparam logic [7:0] PMR_OFF_VERSION = 8'h00;
    localparam logic [7:0] PMR_OFF_ADDR = 8'h01;
    localparam logic [7:0] PMR_OFF_LAMP = 8'h02;
    localparam logic [7:0] PMR_OFF_CYCLES = 8'h03;
    localparam logic [7:0] PMR_OFF_LEVEL = 8'h04;
    localparam logic [7:0] PMR_OFF_MARGIN = 8'h05;
    localparam logic [7:0] PMR_OFF_RTRIM = 8'h06;
    localparam logic [7:0] PMR_OFF_FTRIM = 8'h07;
    localparam logic [7:0] PMR_OFF_VBAT = 8'h1D;
    localparam logic [7:0] PMR_OFF_OUTPUT_VOLTAGE_READING = 8'h1F;
    localparam logic [7:0] PMR_OFF_VIN = 8'h21;
    localparam logic [7:0] PMR_OFF_TOUCH = 8'h23;
    localparam logic [7:0] PMR_LAMP_RESET = 8'h01;
    localparam logic [7:0] PMR_CYCLES_RESET = 8'h14;
    localparam logic [7:0] PMR_LEVEL_RESET = 8'h0C;
    localparam logic [7:0] PMR_MARGIN_RESET = 8'h02;
    localparam logic [7:0] PMR_TRIM_RESET = 8'h00;
    localparam logic [1:0] PMR_LAMP_OFF = 2'h0;
    localparam logic [1:0] PMR_LAMP_ON = 2'h1;
    localparam logic [1:0] PMR_LAMP_PULSE = 2'h2;
    localparam logic [1:0] PMR_LAMP_FAST = 2'h3;
    // history bits that must all be set to count as a long hold
    localparam logic [3:0] PMR_HOLD_MASK = 4'hF;
    // baseline filter shift (1/16 step per tick)
    localparam int PMR_BASE_SHIFT = 4;
    // lamp timing in ns (fast blink half period, pulse ramp period) and derived cycles at 50 MHz
    localparam int PMR_CLK_NS = 20;
    localparam int PMR_FAST_NS = 100_000_000;
    localparam int PMR_FAST_CYC = PMR_FAST_NS / PMR_CLK_NS;
    localparam int PMR_PULSE_NS = 1_000_000_000;
    localparam int PMR_PULSE_CYC = PMR_PULSE_NS / PMR_CLK_NS;
    // pulse pwm resolution: 8-bit duty ramp
    localparam int PMR_PWM_BITS = 8;
    typedef enum logic [3:0] {
        PMR_HOST_OFF = 4'b0001,
        PMR_HOST_BOOT = 4'b0010,
        PMR_HOST_ON = 4'b0100,
        PMR_HOST_SHDN = 4'b1000
    } pmr_host_t;
endpackage

// ---- hw/pmr_touch.sv ----
// touch detector: baseline filter, hysteresis compare, sample history
// assumes one reading per tick, presented with reading_valid
`timescale 1ns/1ps
module pmr_touch
    import pmr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reading_valid,
    input wire logic [15:0] reading,
    input wire logic [7:0] level,
    input wire logic [7:0] margin,
    output logic [3:0] history,
    output logic touched
);
    logic [19:0] base_reg;
    logic [15:0] base;
    logic [17:0] on_mark;
    logic [17:0] off_mark;
    logic primed_reg;
    logic touch_next;

    assign base = base_reg[19:4];
    assign on_mark = {2'b00, base} + {10'h000, level} + {10'h000, margin};
    assign off_mark = ({2'b00, base} + {10'h000, level} > {10'h000, margin})
        ? {2'b00, base} + {10'h000, level} - {10'h000, margin} : 18'h00000;

    // baseline low-pass; frozen while touched so a hold is not absorbed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            base_reg <= 20'h00000;
            primed_reg <= 1'b0;
        end else if (reading_valid) begin
            primed_reg <= 1'b1;
            if (!primed_reg) begin
                base_reg <= {reading, 4'h0};
            end else if (!touched) begin
                base_reg <= base_reg + {4'h0, reading}
                    - {4'h0, base_reg[19:PMR_BASE_SHIFT]};
            end
        end
    end

    // detect decision with hysteresis, also fed to the history
    always_comb begin
        touch_next = touched;
        if (primed_reg && !touched && {2'b00, reading} > on_mark) begin
            touch_next = 1'b1;
        end else if (primed_reg && touched
            && {2'b00, reading} < off_mark) begin
            touch_next = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            touched <= 1'b0;
        end else if (reading_valid) begin
            touched <= touch_next;
        end
    end

    // history shifts in at bit 0
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            history <= 4'h0;
        end else if (reading_valid) begin
            // newest decision, so the byte never lags the pad by a tick
            history <= {history[2:0], touch_next};
        end
    end

    // release only after leaving the band
    a_release_band: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(touched) |-> $past(reading) < $past(off_mark))
        else $error("touch released inside hysteresis band");
    a_hist_shift: assert property (@(posedge clk) disable iff (!reset_n)
        reading_valid |=> history[3:1] == $past(history[2:0]))
        else $error("touch history did not shift upward");
    a_hist_new: assert property (@(posedge clk) disable iff (!reset_n)
        reading_valid |=> history[0] == touched)
        else $error("touch history bit 0 not the newest sample");
endmodule

// ---- testbench/pmr_host_model.sv ----
// host side model: bit-banged i2c master issuing register accesses
// assumes the bench resolves open-drain sda to a pulled-up line
`timescale 1ns/1ps
module pmr_host_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // wide quarter period so synchronised samplers see every edge
    localparam int QTR = 6;
    // released idle bus
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // set both lines just after an edge, then hold a quarter period
    task automatic step(input logic c, input logic d);
        scl = c;
        sda_low = d;
        repeat (QTR) @(posedge clk);
        #1;
    endtask
    // start or repeated start: sda falls while scl is high
    task automatic bus_start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    // scl falls before sda may move, so no false start or stop
    task automatic bit_io(input logic b, output logic got);
        step(1'b0, !b);
        step(1'b1, !b);
        got = sda_line;
        step(1'b1, !b);
        step(1'b0, !b);
    endtask
    // byte plus ack slot; 8'hFF leaves sda free for the slave
    task automatic xfer(input logic [7:0] tx, input logic m_ack,
                        output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(!m_ack, a);
        ack = !a;
    endtask
    // pointer write, then one data byte or a two-byte read, low first
    task automatic access(input logic [6:0] dev, input logic [7:0] ptr,
                          input logic [7:0] data, input logic rnw,
                          output logic [15:0] val, output logic ok);
        logic [7:0] rx;
        logic a1, a2, a3, a4;
        bus_start();
        xfer({dev, 1'b0}, 1'b0, rx, a1);
        xfer(ptr, 1'b0, rx, a2);
        val = 16'h0;
        if (rnw) begin
            bus_start();
            xfer({dev, 1'b1}, 1'b0, rx, a3);
            xfer(8'hFF, 1'b1, val[7:0], a4);
            xfer(8'hFF, 1'b0, val[15:8], a4);
        end else begin
            xfer(data, 1'b0, rx, a3);
        end
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        ok = a1 & a2 & a3;
    endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench: host model drives register reads and writes
// assumes the host model is the sole bus master, 50 MHz clock
`timescale 1ns/1ps
module tb_top
    import pmr_pkg::*;
();
    logic clk, reset_n, sys_tick, store_load, ok;
    logic host_boot_req, host_up, host_down;
    logic [15:0] touch_reading, v;
    logic [9:0] vs [3];
    logic [7:0] st [7];
    logic [7:0] widx, wdat, store_index, store_data, cyc, rtrim, ftrim;
    logic [6:0] dev;
    logic scl, sda_low, sda_out, sda_oe, store_write, power_en, lamp;
    logic [15:0] tr [6] = '{16'd100, 16'd100, 16'd100, 16'd115,
                            16'd113, 16'd109};
    logic [3:0] th [6] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h3, 4'h6};
    int bad_count, num_checks;
    // open-drain sda with pull-up
    wire sda_line = !sda_low && !(sda_oe && !sda_out);
    pmr_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low));
    pmr_regs dut (.clk(clk), .reset_n(reset_n), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .sys_tick(sys_tick), .touch_reading(touch_reading),
        .vbat_sample(vs[0]), .output_voltage_reading_sample(vs[1]), .vin_sample(vs[2]),
        .host_boot_req(host_boot_req), .host_up(host_up),
        .host_down(host_down), .store_addr(st[0]), .store_lamp(st[1]),
        .store_cycles(st[2]), .store_level(st[3]), .store_margin(st[4]),
        .store_rtrim(st[5]), .store_ftrim(st[6]), .store_load(store_load),
        .store_write(store_write), .store_index(store_index),
        .store_data(store_data), .charge_cycles(cyc),
        .osc_range_trim(rtrim), .osc_fine_trim(ftrim),
        .host_power_en(power_en), .power_indicator_lamp(lamp));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] p);
        host.access(dev, p, 8'h00, 1'b1, v, ok);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host.access(dev, p, d, 1'b0, v, ok);
    endtask
    // one system tick carrying a touch reading
    task automatic tick(input logic [15:0] r);
        touch_reading = r;
        sys_tick = 1'b1;
        @(posedge clk);
        #1 sys_tick = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // one-cycle host event: boot request, up, down
    task automatic host_ev(input logic [2:0] e);
        {host_boot_req, host_up, host_down} = e;
        @(posedge clk);
        #1 {host_boot_req, host_up, host_down} = 3'h0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // last byte offered to non-volatile storage
    always @(posedge clk) begin
        if (store_write === 1'b1) begin
            widx <= store_index;
            wdat <= store_data;
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog well beyond the roughly 0.5 ms the sequence needs
    initial begin
        #1_000_000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        {sys_tick, store_load, host_boot_req, host_up, host_down} = 5'h0;
        touch_reading = 16'd100;
        vs = '{10'h2A5, 10'h155, 10'h3FF};
        st = '{8'h43, 8'h00, 8'h30, 8'h0C, 8'h02, 8'h11, 8'h22};
        dev = PMR_ADDR_RESET;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        rd(PMR_OFF_VERSION);
        check(v, {1'b0, PMR_ADDR_RESET, PMR_VERSION});
        check({15'h0, ok}, 16'h1);
        rd(PMR_OFF_LAMP);
        check(v, {PMR_CYCLES_RESET, PMR_LAMP_RESET});
        rd(PMR_OFF_LEVEL);
        check(v, {PMR_MARGIN_RESET, PMR_LEVEL_RESET});
        // read-only places take the write but keep their value
        wr(PMR_OFF_VERSION, 8'hFF);
        wr(PMR_OFF_VBAT, 8'h00);
        rd(PMR_OFF_VERSION);
        check({7'h0, ok, v[7:0]}, {8'h1, PMR_VERSION});
        for (int i = 0; i < 3; i++) begin
            rd(PMR_OFF_VBAT + 8'(2 * i));
            check(v, {6'h0, vs[i]});
        end
        wr(PMR_OFF_CYCLES, 8'h2C);
        check({widx, wdat}, 16'h032C);
        check({8'h0, cyc}, 16'h002C);
        wr(PMR_OFF_RTRIM, 8'h5A);
        wr(PMR_OFF_FTRIM, 8'hA7);
        check({rtrim, ftrim}, 16'h5AA7);
        rd(PMR_OFF_RTRIM);
        check(v, 16'hA75A);
        // wrong address is ignored, then the address is moved
        host.access(7'h44, PMR_OFF_LAMP, 8'h03, 1'b0, v, ok);
        check({15'h0, ok}, 16'h0);
        wr(PMR_OFF_ADDR, 8'h22);
        dev = 7'h22;
        rd(PMR_OFF_LAMP);
        check({7'h0, ok, v[7:0]}, {8'h1, PMR_LAMP_RESET});
        store_load = 1'b1;
        @(posedge clk);
        #1 store_load = 1'b0;
        dev = PMR_ADDR_RESET;
        rd(PMR_OFF_LAMP);
        check(v, 16'h3000);
        check({rtrim, ftrim}, 16'h1122);
        for (int i = 0; i < 6; i++) begin
            tick(tr[i]);
            rd(PMR_OFF_TOUCH);
            check({8'h0, v[7:0]}, {12'h0, th[i]});
        end
        check({14'h0, power_en, lamp}, 16'h0);
        host_ev(3'b100);
        check({15'h0, power_en}, 16'h1);
        host_ev(3'b010);
        check({15'h0, lamp}, 16'h0);
        wr(PMR_OFF_LAMP, {6'h0, PMR_LAMP_ON});
        check({15'h0, lamp}, 16'h1);
        // three touched ticks are only a short touch
        for (int i = 0; i < 4; i++) begin
            tick(i < 3 ? 16'd120 : 16'd100);
        end
        check({14'h0, power_en, lamp}, 16'h3);
        for (int i = 0; i < 4; i++) begin
            tick(16'd120);
        end
        host_ev(3'b001);
        check({14'h0, power_en, lamp}, 16'h0);
        tally_and_finish();
    end
endmodule
